//--- hdl/acp_aux_port.sv
// module: auxiliary control signal port with apb register access
`default_nettype none
module acp_aux_port
   import acp_pkg::*;
#(
   parameter logic [ACP_TMR_W-1:0] PULSE_CYC = ACP_TMR_W'(ACP_SYNC_CYC)
) (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // supply state from core
   input  wire logic        foldback_mode_i,
   input  wire logic        fault_recorded_i,
   input  wire logic        output_change_i,
   // rear pins, inputs
   input  wire logic        shutdown_pin_i,
   input  wire logic        seq_kick_pin_i,
   // open-collector outputs, oe low drives low
   output logic             fold_flag_o,
   output logic             fold_flag_oe_n_o,
   output logic             fault_flag_o,
   output logic             fault_flag_oe_n_o,
   output logic             sync_pulse_o,
   output logic             sync_pulse_oe_n_o,
   // relay drives
   output logic             output_relay_o,
   output logic             remote_sense_relay_o,
   output logic             negative_output_relay_o,
   // to supply core
   output logic             supply_shutdown_o,
   output logic             seq_trigger_o
);
   typedef struct packed {
      logic [31:0]          ctrl;
      logic [31:0]          rdata;
      logic                 ready;
      logic                 err;
      logic [1:0]           shdn_s;
      logic [1:0]           kick_s;
      logic                 kick_d;
      logic                 trig;
      logic                 shdn;
      logic [ACP_CNT_W-1:0] kcnt;
      logic [ACP_CNT_W-1:0] scnt;
      logic                 fold_oe_n;
      logic                 fault_oe_n;
      logic                 sync_oe_n;
      logic                 iso;
      logic                 sense;
      logic                 neg;
   } acp_top_s;

   acp_top_s   st_r;
   acp_top_s   st_nxt;
   acp_sync_if sif ();
   logic       sw_change;
   logic       acc;

   acp_sync_timer #(.PULSE_CYC(PULSE_CYC)) u_tmr (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .sif        (sif)
   );

   // ------------------------------------------------------------
   // combinational next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt    = st_r;
      acc       = psel && penable && !st_r.ready;
      sw_change = 1'b0;
      st_nxt.ready = acc;
      st_nxt.err   = 1'b0;
      st_nxt.rdata = '0;
      if (acc) begin
         if (pwrite) begin
            case (paddr)
               ACP_CTRL_OFF: begin
                  st_nxt.ctrl = pwdata & 32'h0000_001F;
               end
               ACP_CHANGE_OFF: begin
                  sw_change = pwdata[0];
               end
               ACP_STATUS_OFF: begin
               end
               default: begin
                  st_nxt.err = 1'b1;
               end
            endcase
         end else begin
            case (paddr)
               ACP_CTRL_OFF: begin
                  st_nxt.rdata = st_r.ctrl;
               end
               ACP_STATUS_OFF: begin
                  st_nxt.rdata[ACP_STAT_SHDN_BIT] = st_r.shdn;
                  st_nxt.rdata[ACP_STAT_KICK_BIT] = st_r.kick_s[1];
                  st_nxt.rdata[ACP_STAT_SYNC_BIT] = sif.active;
                  st_nxt.rdata[ACP_STAT_KCNT_LSB +: ACP_CNT_W] = st_r.kcnt;
                  st_nxt.rdata[ACP_STAT_SCNT_LSB +: ACP_CNT_W] = st_r.scnt;
               end
               ACP_CHANGE_OFF: begin
               end
               default: begin
                  st_nxt.err = 1'b1;
               end
            endcase
         end
      end
      // pin synchronisers
      st_nxt.shdn_s = {st_r.shdn_s[0], shutdown_pin_i};
      st_nxt.kick_s = {st_r.kick_s[0], seq_kick_pin_i};
      st_nxt.shdn = st_r.shdn_s[1];
      if (st_r.shdn_s[1] && !st_r.shdn) begin
         st_nxt.scnt = st_r.scnt + ACP_CNT_W'(1);
      end
      st_nxt.kick_d = st_r.kick_s[1];
      st_nxt.trig   = st_r.kick_s[1] && !st_r.kick_d;
      if (st_r.kick_s[1] && !st_r.kick_d) begin
         st_nxt.kcnt = st_r.kcnt + ACP_CNT_W'(1);
      end
      st_nxt.fold_oe_n  = !(foldback_mode_i || st_nxt.ctrl[ACP_CTRL_FOLD_BIT]);
      st_nxt.fault_oe_n = !(fault_recorded_i || st_nxt.ctrl[ACP_CTRL_FAULT_BIT]);
      st_nxt.sync_oe_n  = !sif.active;
      st_nxt.iso   = st_nxt.ctrl[ACP_CTRL_ISO_BIT];
      st_nxt.sense = st_nxt.ctrl[ACP_CTRL_SENSE_BIT];
      st_nxt.neg   = st_nxt.ctrl[ACP_CTRL_NEG_BIT];
   end

   assign sif.kick = output_change_i || sw_change;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r            <= '0;
         st_r.ctrl       <= ACP_CTRL_RST;
         st_r.fold_oe_n  <= 1'b1;
         st_r.fault_oe_n <= 1'b1;
         st_r.sync_oe_n  <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata                  = st_r.rdata;
   assign pready                  = st_r.ready;
   assign pslverr                 = st_r.err;
   assign fold_flag_o             = 1'b0;
   assign fold_flag_oe_n_o        = st_r.fold_oe_n;
   assign fault_flag_o            = 1'b0;
   assign fault_flag_oe_n_o       = st_r.fault_oe_n;
   assign sync_pulse_o            = 1'b0;
   assign sync_pulse_oe_n_o       = st_r.sync_oe_n;
   assign output_relay_o          = st_r.iso;
   assign remote_sense_relay_o    = st_r.sense;
   assign negative_output_relay_o = st_r.neg;
   assign supply_shutdown_o       = st_r.shdn;
   assign seq_trigger_o           = st_r.trig;
endmodule : acp_aux_port
`default_nettype wire

//--- common/acp_pkg.sv
// package: register map, fields, reset values and timing for the aux control port
`default_nettype none
package acp_pkg;
   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] ACP_CTRL_OFF   = 12'h000;
   localparam logic [11:0] ACP_STATUS_OFF = 12'h004;
   localparam logic [11:0] ACP_CHANGE_OFF = 12'h008;
   // ------------------------------------------------------------
   // control fields
   // ------------------------------------------------------------
   localparam int ACP_CTRL_ISO_BIT   = 0;
   localparam int ACP_CTRL_SENSE_BIT = 1;
   localparam int ACP_CTRL_NEG_BIT   = 2;
   localparam int ACP_CTRL_FOLD_BIT  = 3;
   localparam int ACP_CTRL_FAULT_BIT = 4;
   localparam logic [31:0] ACP_CTRL_RST = 32'h0000_0000;
   // ------------------------------------------------------------
   // status fields
   // ------------------------------------------------------------
   localparam int ACP_STAT_SHDN_BIT   = 0;
   localparam int ACP_STAT_KICK_BIT   = 1;
   localparam int ACP_STAT_SYNC_BIT   = 2;
   localparam int ACP_STAT_KCNT_LSB   = 8;
   localparam int ACP_STAT_SCNT_LSB   = 16;
   localparam int ACP_CNT_W           = 8;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam longint ACP_CLK_HZ      = 10_000_000;
   localparam longint ACP_SYNC_US     = 10_000;
   localparam longint ACP_SYNC_CYC    = (ACP_SYNC_US * ACP_CLK_HZ) / 1_000_000;
   localparam int     ACP_TMR_W       = 20;
endpackage : acp_pkg
`default_nettype wire

//--- common/acp_sync_if.sv
// interface: change request and pulse state between top and pulse timer
`default_nettype none
interface acp_sync_if;
   logic kick;
   logic active;
   modport ctl (output kick, input active);
   modport tmr (input kick, output active);
endinterface : acp_sync_if
`default_nettype wire

//--- hdl/acp_sync_timer.sv
// module: retriggerable low-active sync pulse timer
`default_nettype none
module acp_sync_timer
   import acp_pkg::*;
#(
   parameter logic [ACP_TMR_W-1:0] PULSE_CYC = ACP_TMR_W'(ACP_SYNC_CYC)
) (
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   // change link
   acp_sync_if.tmr   sif
);
   typedef struct packed {
      logic [ACP_TMR_W-1:0] cnt;
      logic                 act;
   } acp_tmr_s;

   acp_tmr_s st_r;
   acp_tmr_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (sif.kick) begin
         st_nxt.cnt = PULSE_CYC - ACP_TMR_W'(1);
         st_nxt.act = 1'b1;
      end else if (st_r.act) begin
         if (st_r.cnt == '0) begin
            st_nxt.act = 1'b0;
         end else begin
            st_nxt.cnt = st_r.cnt - ACP_TMR_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sif.active = st_r.act;
endmodule : acp_sync_timer
`default_nettype wire

//--- tb/acp_ext_equip.sv
// model: pulled-up rear-panel lines seen by the external equipment
`default_nettype none
module acp_ext_equip (
   // open-collector side
   input  wire logic [2:0] oe_n_i,
   input  wire logic [2:0] drv_i,
   // levels seen by the equipment
   output logic      [2:0] line_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // pull-ups win while the collector is released
   assign line_o = (~oe_n_i & drv_i) | oe_n_i;
endmodule : acp_ext_equip
`default_nettype wire

//--- tb/acp_aux_port_monitor.sv
// checker: port-level assertions for the aux control port
`default_nettype none
module acp_aux_port_monitor
   import acp_pkg::*;
#(parameter logic [ACP_TMR_W-1:0] PULSE_CYC = 20'h0_0008) (
   input wire logic core_clk_i, rst_i, psel, penable, pwrite, pready, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic foldback_mode_i, fault_recorded_i, output_change_i, shutdown_pin_i, seq_kick_pin_i,
   input wire logic fold_flag_o, fold_flag_oe_n_o, fault_flag_o, fault_flag_oe_n_o, sync_pulse_o,
   input wire logic sync_pulse_oe_n_o, output_relay_o, remote_sense_relay_o, negative_output_relay_o,
   input wire logic supply_shutdown_o, seq_trigger_o
);
   logic [ACP_TMR_W:0] cnt_r;
   logic               wr_r;
   logic [2:0]         wd_r;
   // cycles since the last change event, saturating
   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i) cnt_r <= '1;
      else if (output_change_i || (psel && penable && !pready && pwrite && paddr == ACP_CHANGE_OFF && pwdata[0]))
         cnt_r <= '0;
      else if (cnt_r != '1) cnt_r <= cnt_r + 1'h1;
   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i) wr_r <= 1'h0;
      else wr_r <= psel && penable && pwrite && paddr == ACP_CTRL_OFF;
   always_ff @(posedge core_clk_i) wd_r <= pwdata[2:0];
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_shdn_hi; shutdown_pin_i [*4]; endsequence
   sequence s_shdn_lo; !shutdown_pin_i [*4]; endsequence
   property p_fold; foldback_mode_i |=> !fold_flag_oe_n_o; endproperty
   property p_fault; fault_recorded_i |=> !fault_flag_oe_n_o; endproperty
   property p_sync_hold; output_change_i |-> ##2 !sync_pulse_oe_n_o [*8]; endproperty
   property p_sync_end; cnt_r > PULSE_CYC |-> sync_pulse_oe_n_o; endproperty
   property p_shdn_on; s_shdn_hi |-> supply_shutdown_o; endproperty
   property p_shdn_off; s_shdn_lo |-> !supply_shutdown_o; endproperty
   property p_kick; $rose(seq_kick_pin_i) |-> ##[1:6] seq_trigger_o; endproperty
   property p_relay;
      $changed({negative_output_relay_o, remote_sense_relay_o, output_relay_o}) |->
         wr_r && {negative_output_relay_o, remote_sense_relay_o, output_relay_o} == wd_r;
   endproperty
   property p_ready; psel && penable && !pready |=> pready ##1 !pready; endproperty
   a_fold: assert property (p_fold) else $error("fold flag not asserted");
   a_fault: assert property (p_fault) else $error("fault flag not asserted");
   a_sync_hold: assert property (p_sync_hold) else $error("sync pulse too short");
   a_sync_end: assert property (p_sync_end) else $error("sync pulse too long");
   a_shdn_on: assert property (p_shdn_on) else $error("shutdown not applied");
   a_shdn_off: assert property (p_shdn_off) else $error("shutdown stuck");
   a_kick: assert property (p_kick) else $error("no trigger after kick");
   a_relay: assert property (p_relay) else $error("relay differs from command");
   a_ready: assert property (p_ready) else $error("apb answer timing wrong");
endmodule : acp_aux_port_monitor
bind acp_aux_port acp_aux_port_monitor #(.PULSE_CYC(PULSE_CYC)) u_mon (.*);
`default_nettype wire

//--- tb/acp_aux_port_tb_top.sv
// testbench: apb and pin tests of the aux control port
`default_nettype none
module acp_aux_port_tb_top
   import acp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic        fold_m = 0, fault_m = 0, chg = 0, shdn = 0, kick = 0, sshdn, trig;
   logic [2:0]  oe_n, drv, line, rly;
   int          mismatches = 0, n_compared = 0, cyc = 0, low_cnt = 0, trig_cnt = 0;
   acp_aux_port #(.PULSE_CYC(20'h0_0008)) u_dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .foldback_mode_i(fold_m),
      .fault_recorded_i(fault_m), .output_change_i(chg), .shutdown_pin_i(shdn), .seq_kick_pin_i(kick),
      .fold_flag_o(drv[0]), .fold_flag_oe_n_o(oe_n[0]), .fault_flag_o(drv[1]), .fault_flag_oe_n_o(oe_n[1]),
      .sync_pulse_o(drv[2]), .sync_pulse_oe_n_o(oe_n[2]), .output_relay_o(rly[0]),
      .remote_sense_relay_o(rly[1]), .negative_output_relay_o(rly[2]), .supply_shutdown_o(sshdn),
      .seq_trigger_o(trig));
   acp_ext_equip u_eq (.oe_n_i(oe_n), .drv_i(drv), .line_o(line));
   initial forever #50 core_clk_i = ~core_clk_i;
   always @(negedge core_clk_i) begin
      low_cnt += int'(line[2] === 1'h0);
      trig_cnt += int'(trig === 1'h1);
   end
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 4000) begin
         mismatches++;
         complete_run();
      end
   end
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'h1;
      do @(posedge core_clk_i); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic pins(input logic f, input logic t, input logic s, input logic k, input int n);
      @(posedge core_clk_i);
      fold_m <= f;
      fault_m <= t;
      shdn <= s;
      kick <= k;
      repeat (n) @(negedge core_clk_i);
   endtask : pins
   task automatic pulse_chg;
      @(posedge core_clk_i);
      chg <= 1'h1;
      @(posedge core_clk_i);
      chg <= 1'h0;
   endtask : pulse_chg
   initial begin
      repeat (4) @(posedge core_clk_i);
      rst_i <= 1'h0;
      @(negedge core_clk_i);
      chk("lines idle", line, 3'h7);
      chk("relays idle", rly, 3'h0);
      for (int i = 0; i < 8; i++) begin
         apb(1'h1, ACP_CTRL_OFF, 32'(i));
         apb(1'h0, ACP_CTRL_OFF, '0);
         chk("relays", rly, 32'(i));
         chk("ctrl", q, 32'(i));
      end
      pins(1'h1, 1'h0, 1'h0, 1'h0, 2);
      chk("fold line", line, 3'h6);
      pins(1'h0, 1'h1, 1'h0, 1'h0, 2);
      chk("fault line", line, 3'h5);
      pins(1'h0, 1'h0, 1'h0, 1'h0, 2);
      chk("lines released", line, 3'h7);
      low_cnt = 0;
      pulse_chg();
      pins(1'h0, 1'h0, 1'h0, 1'h0, 12);
      chk("sync length", low_cnt, 32'h0000_0008);
      low_cnt = 0;
      pulse_chg();
      pulse_chg();
      pins(1'h0, 1'h0, 1'h0, 1'h0, 14);
      chk("sync restart", low_cnt, 32'h0000_000A);
      low_cnt = 0;
      apb(1'h1, ACP_CHANGE_OFF, 32'h0000_0001);
      pins(1'h0, 1'h0, 1'h0, 1'h0, 12);
      chk("sync by write", low_cnt, 32'h0000_0008);
      pins(1'h0, 1'h0, 1'h1, 1'h0, 5);
      chk("shutdown", sshdn, 1'h1);
      pins(1'h0, 1'h0, 1'h0, 1'h0, 5);
      chk("shutdown off", sshdn, 1'h0);
      trig_cnt = 0;
      pins(1'h0, 1'h0, 1'h0, 1'h1, 10);
      pins(1'h0, 1'h0, 1'h0, 1'h0, 6);
      chk("triggers", trig_cnt, 32'h0000_0001);
      apb(1'h0, ACP_STATUS_OFF, '0);
      chk("kick count", q[15:8], 8'h01);
      apb(1'h0, 12'h00C, '0);
      chk("unmapped err", e, 1'h1);
      chk("unmapped data", q, 32'h0000_0000);
      complete_run();
   end
endmodule : acp_aux_port_tb_top
`default_nettype wire
